// >>> err_report_pkg.sv
// package: error codes, status bit layout and event carrier for error reporting
// How it works
// - error query answers latched code, zero means none
// - error query clears programming error status flag
// - bad character or malformed number records code four
// - unknown or misplaced command token records four
// - parameter outside permitted range records code five
// - setpoint above soft limit records code six
// - soft limit below present setting records seven
// - response requested without query records code eight
// - trip level below output voltage records nine
// - secondary processor silent records code ten
// - calibration command outside calibration mode records twelve
// - bus timeout recovery lights green indicator
// - bus timeout recovery leaves serial link untouched
// - primary restart lights first red indicator
// - secondary restart lights second red indicator
// - reset command turns off all three indicators
// - rejected soft limit lights error, sets flag
// - programming error flag sits at bit seven
package err_report_pkg;
	localparam int CODE_W = 4;
	localparam logic [3:0] CODE_NONE      = 4'h0;
	localparam logic [3:0] CODE_SYNTAX    = 4'h4;
	localparam logic [3:0] CODE_RANGE     = 4'h5;
	localparam logic [3:0] CODE_SOFT_LIM  = 4'h6;
	localparam logic [3:0] CODE_BAD_LIMIT = 4'h7;
	localparam logic [3:0] CODE_NO_QUERY  = 4'h8;
	localparam logic [3:0] CODE_TRIP_LOW  = 4'h9;
	localparam logic [3:0] CODE_NO_SLAVE  = 4'hA;
	localparam logic [3:0] CODE_CAL_ILLEG = 4'hC;
	localparam int STAT_W       = 13;
	localparam int ERR_BIT_POS  = 7;
	localparam logic [12:0] STAT_RESET = 13'h0000;
	localparam int SYNC_STAGES  = 3;

	// one-cycle failure reports from the command parser
	typedef struct packed {
		logic bad_char;
		logic bad_number;
		logic unknown_word;
		logic misplaced_token;
		logic out_of_range;
		logic over_soft_limit;
		logic limit_below_set;
		logic read_without_query;
		logic trip_below_output;
		logic slave_silent;
		logic cal_not_enabled;
	} cmd_fail_s;

	// asynchronous recovery events from the processor watchdogs
	typedef struct packed {
		logic bus_timeout_recovered;
		logic primary_restart;
		logic secondary_restart;
	} recovery_s;
endpackage

// >>> error_code_reporting.sv
// error code latching, status error flag and recovery indicators
`timescale 1ns/1ps
`default_nettype none
module error_code_reporting
	import err_report_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire cmd_fail_s         fail_i,
	input  wire logic              err_query_i,
	input  wire logic              reset_cmd_i,
	input  wire logic              calibration_mode_switch_i,
	input  wire logic              cal_cmd_i,
	input  wire recovery_s         recovery_i,
	input  wire logic [STAT_W-1:0] status_cond_i,
	output logic [CODE_W-1:0]      err_code_o,
	output logic                   err_code_valid_o,
	output logic [STAT_W-1:0]      status_o,
	output logic                   err_led_o,
	output logic                   recovery_green_o,
	output logic                   recovery_red_primary_o,
	output logic                   recovery_red_secondary_o
);
	logic [CODE_W-1:0] code;
	logic [CODE_W-1:0] next_code;
	logic              err_flag;
	logic              next_err_flag;
	logic [CODE_W-1:0] next_err_code_o;
	logic              next_err_code_valid_o;
	logic [STAT_W-1:0] next_status_o;
	logic              next_green;
	logic              next_red_p;
	logic              next_red_s;
	logic              green_ev;
	logic              red_p_ev;
	logic              red_s_ev;
	logic              cal_illegal;
	logic              any_fail;
	logic [CODE_W-1:0] new_code;

	// maps a failure bundle to a code; later-listed classes win on ties
	function automatic logic [CODE_W-1:0] classify(input cmd_fail_s f,
		input logic cal_bad);
		logic [CODE_W-1:0] c;
		c = CODE_NONE;
		if (f.bad_char || f.bad_number)
			c = CODE_SYNTAX;
		if (f.unknown_word || f.misplaced_token)
			c = CODE_SYNTAX;
		if (f.out_of_range)
			c = CODE_RANGE;
		if (f.over_soft_limit)
			c = CODE_SOFT_LIM;
		if (f.limit_below_set)
			c = CODE_BAD_LIMIT;
		if (f.read_without_query)
			c = CODE_NO_QUERY;
		if (f.trip_below_output)
			c = CODE_TRIP_LOW;
		if (f.slave_silent)
			c = CODE_NO_SLAVE;
		if (f.cal_not_enabled || cal_bad)
			c = CODE_CAL_ILLEG;
		return c;
	endfunction

	// recovery events come from free-running watchdog logic, so synchronise
	pulse_sync u_sync_green (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (recovery_i.bus_timeout_recovered),
		.rise_o     (green_ev)
	);
	pulse_sync u_sync_red_p (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (recovery_i.primary_restart),
		.rise_o     (red_p_ev)
	);
	pulse_sync u_sync_red_s (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (recovery_i.secondary_restart),
		.rise_o     (red_s_ev)
	);

	assign cal_illegal = cal_cmd_i & ~calibration_mode_switch_i;
	assign new_code    = classify(fail_i, cal_illegal);
	assign any_fail    = (new_code != CODE_NONE);

	// error latch: a new failure in the query cycle survives the clear
	always_comb
	begin
		next_code             = code;
		next_err_flag         = err_flag;
		next_err_code_o       = err_code_o;
		next_err_code_valid_o = 1'b0;
		if (err_query_i)
		begin
			next_err_code_o       = code;
			next_err_code_valid_o = 1'b1;
			next_code             = CODE_NONE;
			next_err_flag         = 1'b0;
		end
		if (any_fail)
		begin
			next_code     = new_code;
			next_err_flag = 1'b1;
		end
	end

	// status word: live conditions with the error flag merged at bit seven
	always_comb
	begin
		next_status_o              = status_cond_i;
		next_status_o[ERR_BIT_POS] = next_err_flag;
	end

	// indicators set on events; reset command clears, a same-cycle event wins
	always_comb
	begin
		next_green = recovery_green_o;
		next_red_p = recovery_red_primary_o;
		next_red_s = recovery_red_secondary_o;
		if (reset_cmd_i)
		begin
			next_green = 1'b0;
			next_red_p = 1'b0;
			next_red_s = 1'b0;
		end
		if (green_ev)
			next_green = 1'b1;
		if (red_p_ev)
			next_red_p = 1'b1;
		if (red_s_ev)
			next_red_s = 1'b1;
	end

	// the serial path has no input from recovery logic at all
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			code                     <= CODE_NONE;
			err_flag                 <= 1'b0;
			err_code_o               <= CODE_NONE;
			err_code_valid_o         <= 1'b0;
			status_o                 <= STAT_RESET;
			err_led_o                <= 1'b0;
			recovery_green_o         <= 1'b0;
			recovery_red_primary_o   <= 1'b0;
			recovery_red_secondary_o <= 1'b0;
		end
		else
		begin
			code                     <= next_code;
			err_flag                 <= next_err_flag;
			err_code_o               <= next_err_code_o;
			err_code_valid_o         <= next_err_code_valid_o;
			status_o                 <= next_status_o;
			err_led_o                <= next_err_flag;
			recovery_green_o         <= next_green;
			recovery_red_primary_o   <= next_red_p;
			recovery_red_secondary_o <= next_red_s;
		end
	end

	// query reports the code latched before it
	property p_query_reports;
		@(posedge core_clk_i) disable iff (rst_i)
		err_query_i |=> (err_code_valid_o && err_code_o == $past(code));
	endproperty
	a_query_reports_code: assert property (p_query_reports)
		else $error("query did not return latched code");

	a_query_clears_flag: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(err_query_i && !any_fail) |=> (!err_flag && code == CODE_NONE
			&& !status_o[ERR_BIT_POS] && !err_led_o))
		else $error("query left error flag set");

	a_char_code_four: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		((fail_i.bad_char || fail_i.bad_number) && fail_i[6:0] == 7'h00
			&& !cal_illegal) |=> code == CODE_SYNTAX)
		else $error("bad character not recorded as four");

	a_word_code_four: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		((fail_i.unknown_word || fail_i.misplaced_token)
			&& fail_i[6:0] == 7'h00 && !cal_illegal)
		|=> code == CODE_SYNTAX)
		else $error("bad command word not recorded as four");

	a_range_code_five: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(fail_i.out_of_range && fail_i[5:0] == 6'h00 && !cal_illegal)
		|=> code == CODE_RANGE)
		else $error("range failure not recorded as five");

	a_limit_code_six: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(fail_i.over_soft_limit && fail_i[4:0] == 5'h00 && !cal_illegal)
		|=> code == CODE_SOFT_LIM)
		else $error("soft limit failure not recorded as six");

	a_limit_code_seven: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(fail_i.limit_below_set && fail_i[3:0] == 4'h0 && !cal_illegal)
		|=> code == CODE_BAD_LIMIT)
		else $error("improper soft limit not recorded as seven");

	a_query_code_eight: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(fail_i.read_without_query && fail_i[2:0] == 3'h0 && !cal_illegal)
		|=> code == CODE_NO_QUERY)
		else $error("read without query not recorded as eight");

	a_trip_code_nine: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(fail_i.trip_below_output && fail_i[1:0] == 2'h0 && !cal_illegal)
		|=> code == CODE_TRIP_LOW)
		else $error("low trip level not recorded as nine");

	a_silent_code_ten: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(fail_i.slave_silent && !fail_i.cal_not_enabled && !cal_illegal)
		|=> code == CODE_NO_SLAVE)
		else $error("silent processor not recorded as ten");

	a_cal_code_twelve: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		cal_illegal |=> code == CODE_CAL_ILLEG)
		else $error("illegal calibration not recorded as twelve");

	a_err_led_follows: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		any_fail |=> (err_flag && err_led_o && status_o[ERR_BIT_POS]))
		else $error("error indicator or status flag missing");

	a_status_passes: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		1'b1 |=> (status_o[ERR_BIT_POS-1:0]
			== $past(status_cond_i[ERR_BIT_POS-1:0])
			&& status_o[STAT_W-1:ERR_BIT_POS+1]
			== $past(status_cond_i[STAT_W-1:ERR_BIT_POS+1])))
		else $error("status conditions not passed through");

	a_answer_holds: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!err_query_i |=> $stable(err_code_o))
		else $error("answered code changed without a query");

	a_valid_one_cycle: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(err_code_valid_o && !err_query_i) |=> !err_code_valid_o)
		else $error("answer valid stood longer than one cycle");

	// two failures back to back: the later one must own the code
	sequence s_any_fail;
		any_fail;
	endsequence
	sequence s_limit_fail;
		fail_i.limit_below_set && fail_i[3:0] == 4'h0 && !cal_illegal;
	endsequence
	a_latest_code_wins: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(s_any_fail ##1 s_limit_fail) |=> code == CODE_BAD_LIMIT)
		else $error("later failure did not replace earlier code");

	// watchdog recoveries must leave the error latch alone
	a_recovery_spares_code: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		((green_ev || red_p_ev || red_s_ev) && !any_fail && !err_query_i)
		|=> ($stable(code) && $stable(err_flag)))
		else $error("recovery event disturbed the error latch");

	// levels cross three flops, so the lamp follows within a small window
	sequence s_green_rise;
		$rose(recovery_i.bus_timeout_recovered) && !reset_cmd_i;
	endsequence
	sequence s_lit_green;
		##[3:6] recovery_green_o;
	endsequence
	a_green_lights: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_green_rise |-> s_lit_green)
		else $error("green indicator not lit after recovery");

	sequence s_red_p_rise;
		$rose(recovery_i.primary_restart) && !reset_cmd_i;
	endsequence
	sequence s_lit_red_p;
		##[3:6] recovery_red_primary_o;
	endsequence
	a_red_primary_lights: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_red_p_rise |-> s_lit_red_p)
		else $error("first red indicator not lit after restart");

	sequence s_red_s_rise;
		$rose(recovery_i.secondary_restart) && !reset_cmd_i;
	endsequence
	sequence s_lit_red_s;
		##[3:6] recovery_red_secondary_o;
	endsequence
	a_red_secondary_lights: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		s_red_s_rise |-> s_lit_red_s)
		else $error("second red indicator not lit after restart");

	a_reset_clears_leds: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(reset_cmd_i && !green_ev && !red_p_ev && !red_s_ev) |=>
		(!recovery_green_o && !recovery_red_primary_o
			&& !recovery_red_secondary_o))
		else $error("reset command left an indicator lit");
endmodule
`default_nettype wire

// >>> error_code_reporting_tb.sv
// self-checking bench for error code reporting
`timescale 1ns/1ps
`default_nettype none
module error_code_reporting_tb
	import err_report_pkg::*;
;
	logic              core_clk_i;
	logic              rst_i;
	logic              mode;
	cmd_fail_s         fail;
	logic              query;
	logic              rcmd;
	logic              cal;
	recovery_s         rec;
	logic [STAT_W-1:0] cond;
	logic [STAT_W-1:0] stat;
	logic [CODE_W-1:0] code;
	logic              valid;
	logic              led;
	logic              green;
	logic              redp;
	logic              reds;
	int                n_fail;
	int                comparisons;
	logic [3:0]        codes [11] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6,
		4'h7, 4'h8, 4'h9, 4'hA, 4'hC};

	host_cmd_model host_u (
		.core_clk_i  (core_clk_i),
		.fail_o      (fail),
		.query_o     (query),
		.reset_cmd_o (rcmd),
		.cal_cmd_o   (cal)
	);

	error_code_reporting dut_u (
		.core_clk_i                (core_clk_i),
		.rst_i                     (rst_i),
		.fail_i                    (fail),
		.err_query_i               (query),
		.reset_cmd_i               (rcmd),
		.calibration_mode_switch_i (mode),
		.cal_cmd_i                 (cal),
		.recovery_i                (rec),
		.status_cond_i             (cond),
		.err_code_o                (code),
		.err_code_valid_o          (valid),
		.status_o                  (stat),
		.err_led_o                 (led),
		.recovery_green_o          (green),
		.recovery_red_primary_o    (redp),
		.recovery_red_secondary_o  (reds)
	);

	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic print_verdict;
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// sample one step past the edge so its updates have landed
	task automatic tick;
		@(posedge core_clk_i);
		#1;
	endtask

	// error query: answer, cleared flag and dark lamp stand after the take
	task automatic ask(input logic [3:0] exp);
		host_u.send('0, 1'b1, 1'b0, 1'b0);
		#1;
		chk(13'(valid), 13'h0001);
		chk(13'(code), 13'(exp));
		chk(stat, 13'h1F7F);
		tick();
		chk(13'(valid), 13'h0000);
		chk(13'(led), 13'h0000);
	endtask

	// one failure: flag at bit 7 and lamp at the taking edge, then query
	task automatic hit(input cmd_fail_s f, input logic c, input logic [3:0] e);
		host_u.send(f, 1'b0, 1'b0, c);
		#1;
		chk(stat, 13'h1FFF);
		chk(13'(led), 13'h0001);
		tick();
		chk(13'(led), 13'h0001);
		ask(e);
	endtask

	// recovery levels cross a synchroniser, so the wait is bounded, not fixed
	task automatic raise(input logic [2:0] b);
		int k;
		@(posedge core_clk_i);
		rec <= recovery_s'(b);
		for (k = 0; k < 8 && {green, redp, reds} !== b; k++)
			tick();
		if (k == 8)
		begin
			n_fail++;
			$display("[ERR] %0t indicator wait ran out", $time);
			print_verdict();
		end
		chk(13'({green, redp, reds}), 13'(b));
	endtask

	initial
	begin
		n_fail = 0;
		comparisons = 0;
		rst_i = 1'b1;
		mode = 1'b0;
		rec = '0;
		cond = 13'h1FFF;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		chk(stat, 13'h0000);
		ask(4'h0);
		for (int i = 0; i < 11; i++)
			hit(11'h400 >> i, 1'b0, codes[i]);
		hit('0, 1'b1, 4'hC);
		@(posedge core_clk_i);
		mode <= 1'b1;
		host_u.send('0, 1'b0, 1'b0, 1'b1);
		tick();
		chk(stat, 13'h1F7F);
		ask(4'h0);
		host_u.send_two(cmd_fail_s'(11'h040), cmd_fail_s'(11'h010));
		tick();
		ask(4'h7);
		ask(4'h0);
		raise(3'b100);
		ask(4'h0);
		raise(3'b110);
		raise(3'b111);
		host_u.send('0, 1'b0, 1'b1, 1'b0);
		tick();
		chk(13'({green, redp, reds}), 13'h0000);
		print_verdict();
	end
endmodule
`default_nettype wire

// >>> host_cmd_model.sv
// host model: parser pulses and command strobes, one cycle wide each
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model
	import err_report_pkg::*;
(
	input  wire logic core_clk_i,
	output cmd_fail_s fail_o,
	output logic      query_o,
	output logic      reset_cmd_o,
	output logic      cal_cmd_o
);
	// idle at time zero so the block never sees an unknown request
	initial
	begin
		fail_o = '0;
		query_o = 1'b0;
		reset_cmd_o = 1'b0;
		cal_cmd_o = 1'b0;
	end

	// raised after one edge, dropped after the next: the block takes it once
	task automatic send(input cmd_fail_s f, input logic q,
		input logic r, input logic c);
		@(posedge core_clk_i);
		fail_o <= f;
		query_o <= q;
		reset_cmd_o <= r;
		cal_cmd_o <= c;
		@(posedge core_clk_i);
		fail_o <= '0;
		query_o <= 1'b0;
		reset_cmd_o <= 1'b0;
		cal_cmd_o <= 1'b0;
	endtask

	// two failures in adjacent cycles, no idle gap between them
	task automatic send_two(input cmd_fail_s a, input cmd_fail_s b);
		@(posedge core_clk_i);
		fail_o <= a;
		@(posedge core_clk_i);
		fail_o <= b;
		@(posedge core_clk_i);
		fail_o <= '0;
	endtask
endmodule
`default_nettype wire

// >>> pulse_sync.sv
// three-stage synchroniser with agreement-based edge detection
`timescale 1ns/1ps
`default_nettype none
module pulse_sync
	import err_report_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      rise_o
);
	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;
	logic                   level;
	logic                   next_level;
	logic                   next_rise;

	// stage[0] feeds only stage[1]; a level counts once stages 1 and 2 agree
	always_comb
	begin
		next_stage = {stage[1:0], async_i};
		next_level = level;
		if (stage[1] == stage[2])
			next_level = stage[2];
		next_rise = next_level & ~level;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stage  <= '0;
			level  <= 1'b0;
			rise_o <= 1'b0;
		end
		else
		begin
			stage  <= next_stage;
			level  <= next_level;
			rise_o <= next_rise;
		end
	end
endmodule
`default_nettype wire
